/* rsom_line_reader.sv */
// rsom_line_reader: external circuitry reading the mapper's output lines
// assumes a pull-up on every line, so a line nobody drives reads high
`timescale 1ns/1ps
`default_nettype none

module rsom_line_reader #(
  parameter int NUM_LINES = 8
) (
  // lines from the mapper
  input wire logic [NUM_LINES-1:0] line_out,
  input wire logic [NUM_LINES-1:0] line_oe,
  // level seen at the connector
  output logic [NUM_LINES-1:0] pin_level
);
  // a released line never keeps its last value: the pull-up wins
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      pin_level[i] = line_oe[i] ? line_out[i] : 1'b1;
    end
  end
endmodule

`default_nettype wire

/* rsom_mapper.sv */
// rsom_mapper: maps radio status conditions onto programmable output lines
// assumes status inputs come from radio logic on aclk (mirror input from a pin)
// Contract
// [R1] - ffsk line follows valid data reception
// [R2] - hookswitch line follows mic off hook
// [R3] - monitor line, except hookswitch-opened monitor
// [R4] - unassigned line idle unless mirror destination
// [R5] - data traffic line in trunked mode
// [R6] - public address line: pa mode and ptt
// [R7] - integrator puts pa on line two high
// [R8] - service line while trunked service present
// [R9] - idle line while trunked and call-ready
// [R10] - traffic line on voice or data channel
// [R11] - ready line when initialised, not mode change
// [R12] - stunned line: stun sets, revive clears
// [R13] - no stun in trunked mode
// [R14] - tx status line while transmitting rf
// [R15] - packet data line when over-air data possible
// [R16] - ptt inhibit line follows inhibit
// [R17] - reflected ptt line follows reflected ptts
// [R18] - modem line while transparent mode active
// [R19] - serial tx line ignores positioning port
// [R20] - tone line set on tone, cleared on carrier loss
// [R21] - mute line on valid traffic until mute closes
// [R22] - each line has configurable active level
// [R23] - lines float up to settle time
// [R24] - one action per line, lines independent
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rsom_mapper #(
  parameter int NUM_LINES = rsom_pkg::RSOM_NUM_LINES,
  parameter int SETTLE_CYC = rsom_pkg::RSOM_SETTLE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // radio status sources, all on aclk
  input wire logic ffsk_data_valid,
  input wire logic mic_off_hook,
  input wire logic monitor_open,
  input wire logic monitor_by_hook,
  input wire logic on_data_traffic,
  input wire logic on_voice_traffic,
  input wire logic public_addr_mode,
  input wire logic ptt_active,
  input wire logic has_service,
  input wire logic call_idle,
  input wire logic initialised,
  input wire logic mode_changing,
  input wire logic stun_cmd,
  input wire logic revive_cmd,
  input wire logic rf_transmitting,
  input wire logic data_call_possible,
  input wire logic hunting_or_setup,
  input wire logic ptt_inhibited,
  input wire logic reflected_ptt_active,
  input wire logic high_speed_data_modem,
  input wire logic serial_tx_busy,
  input wire logic inband_tone_valid,
  input wire logic carrier_detect,
  input wire logic valid_traffic,
  input wire logic audio_mute_open,
  // external pin mirrored onto a chosen line
  input wire logic mirror_pin,
  // output lines, two signals each
  output logic [NUM_LINES-1:0] line_out,
  output logic [NUM_LINES-1:0] line_oe
);

  localparam int AW = rsom_pkg::RSOM_ACT_W;

  // configuration registers
  logic [31:0] ctrl_reg;
  logic [NUM_LINES-1:0] pol_reg; // 1 = active high
  logic [8:0] mirror_reg;
  logic [AW-1:0] act_reg [NUM_LINES];
  // held condition flags
  logic stun_reg;
  logic tone_reg;
  logic mute_reg;
  logic ffsk_reg;
  logic [31:0] settle_reg;
  logic settled_reg;
  // mirror pin synchroniser
  logic mir_s1_reg;
  logic mir_s2_reg;
  // condition vector, one bit per action code
  logic [31:0] cond;
  logic trunked;

  assign trunked = ctrl_reg[rsom_pkg::RSOM_CTRL_TRUNKED];

  // pin synchroniser; first stage read only by second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mir_s1_reg <= 1'b0;
      mir_s2_reg <= 1'b0;
    end else begin
      mir_s1_reg <= mirror_pin;
      mir_s2_reg <= mir_s1_reg;
    end
  end

  // power-up settle counter; lines float until it expires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_reg <= 32'h0000_0000;
      settled_reg <= 1'b0;
    end else if (!settled_reg) begin
      settle_reg <= settle_reg + 32'h0000_0001;
      if (settle_reg >= 32'(SETTLE_CYC - 1)) begin
        settled_reg <= 1'b1; // [R23]
      end
    end
  end

  // stun latch; stun wins if both arrive together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stun_reg <= 1'b0;
    end else if (!trunked) begin
      if (stun_cmd) begin
        stun_reg <= 1'b1; // [R12]
      end else if (revive_cmd) begin
        stun_reg <= 1'b0; // [R12]
      end
    end
  end

  // tone held until carrier ends; a tone without carrier does not set it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_reg <= 1'b0;
    end else if (inband_tone_valid && carrier_detect) begin
      tone_reg <= 1'b1; // [R20]
    end else if (!carrier_detect) begin
      tone_reg <= 1'b0; // [R20]
    end
  end

  // mute status held from valid traffic until mute closes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mute_reg <= 1'b0;
    end else if (valid_traffic) begin
      mute_reg <= 1'b1; // [R21]
    end else if (!audio_mute_open) begin
      mute_reg <= 1'b0; // [R21]
    end
  end

  // ffsk reception flag tracks validity directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ffsk_reg <= 1'b0;
    end else begin
      ffsk_reg <= ffsk_data_valid; // [R1]
    end
  end

  // condition vector indexed by action code
  always_comb begin
    cond = 32'h0000_0000;
    cond[rsom_pkg::RSOM_ACT_FFSK_DATA] = ffsk_reg; // [R1]
    cond[rsom_pkg::RSOM_ACT_HOOKSWITCH] = mic_off_hook; // [R2]
    cond[rsom_pkg::RSOM_ACT_MONITOR] = monitor_open && !monitor_by_hook; // [R3]
    cond[rsom_pkg::RSOM_ACT_DATA_TRAFFIC] = trunked && on_data_traffic; // [R5]
    cond[rsom_pkg::RSOM_ACT_PUBLIC_ADDR] = public_addr_mode && ptt_active; // [R6]
    cond[rsom_pkg::RSOM_ACT_SERVICE] = trunked && has_service; // [R8]
    cond[rsom_pkg::RSOM_ACT_IDLE] = trunked && call_idle; // [R9]
    cond[rsom_pkg::RSOM_ACT_TRAFFIC] =
      trunked && (on_voice_traffic || on_data_traffic); // [R10]
    cond[rsom_pkg::RSOM_ACT_READY] = initialised && !mode_changing; // [R11]
    cond[rsom_pkg::RSOM_ACT_STUNNED] = stun_reg && !trunked; // [R13]
    cond[rsom_pkg::RSOM_ACT_TX_STATUS] = rf_transmitting; // [R14]
    cond[rsom_pkg::RSOM_ACT_PACKET_READY] = trunked && !hunting_or_setup
      && (data_call_possible || on_data_traffic); // [R15]
    cond[rsom_pkg::RSOM_ACT_PTT_INHIBIT] = ptt_inhibited; // [R16]
    cond[rsom_pkg::RSOM_ACT_REFLECT_PTT] = reflected_ptt_active; // [R17]
    cond[rsom_pkg::RSOM_ACT_MODEM] = high_speed_data_modem; // [R18]
    cond[rsom_pkg::RSOM_ACT_SERIAL_TX] = serial_tx_busy; // [R19]
    cond[rsom_pkg::RSOM_ACT_INBAND_TONE] = tone_reg; // [R20]
    cond[rsom_pkg::RSOM_ACT_SIG_MUTE] = mute_reg; // [R21]
  end

  // per-line output stage; each line looks only at its own action, or at the synchronised pin when it is the mirror destination
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      logic active;
      logic is_mirror;
      // mirror destination overrides the assigned action
      assign is_mirror = mirror_reg[rsom_pkg::RSOM_MIR_EN]
        && (mirror_reg[2:0] == 3'(gi));
      // no-action code maps to cond bit 0, always low
      assign active = is_mirror ? mir_s2_reg : cond[act_reg[gi]]; // [R4] [R24]
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          line_out[gi] <= 1'b0;
          line_oe[gi] <= 1'b0;
        end else begin
          line_oe[gi] <= settled_reg && ctrl_reg[rsom_pkg::RSOM_CTRL_ENABLE]; // [R23]
          line_out[gi] <= active ~^ pol_reg[gi]; // [R22]
        end
      end
    end
  endgenerate

  // write channel: address and data taken in either order
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic wr_hit;
  logic [31:0] wmask;

  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // capture address and data, ready low while holding one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // address decode of a write
  always_comb begin
    wr_hit = 1'b1;
    case (aw_addr_reg)
      rsom_pkg::RSOM_OFF_CTRL: wr_hit = 1'b1;
      rsom_pkg::RSOM_OFF_POL: wr_hit = 1'b1;
      rsom_pkg::RSOM_OFF_MIRROR: wr_hit = 1'b1;
      default: begin
        // action words sit at act0 + 4*line
        wr_hit = (aw_addr_reg >= rsom_pkg::RSOM_OFF_ACT0) && (aw_addr_reg[1:0] == 2'h0)
          && (aw_addr_reg < 8'(rsom_pkg::RSOM_OFF_ACT0 + 4 * NUM_LINES));
      end
    endcase
  end

  // register writes and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= rsom_pkg::RSOM_CTRL_RESET;
      pol_reg <= NUM_LINES'(rsom_pkg::RSOM_POL_RESET);
      mirror_reg <= 9'h000;
      for (int i = 0; i < NUM_LINES; i++) begin
        act_reg[i] <= rsom_pkg::RSOM_ACT_RESET;
      end
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsom_pkg::RSOM_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? rsom_pkg::RSOM_RESP_OKAY : rsom_pkg::RSOM_RESP_SLVERR;
        case (aw_addr_reg)
          rsom_pkg::RSOM_OFF_CTRL: ctrl_reg <= (ctrl_reg & ~wmask) | (w_data_reg & wmask);
          rsom_pkg::RSOM_OFF_POL: begin
            pol_reg <= NUM_LINES'((32'(pol_reg) & ~wmask) | (w_data_reg & wmask)); // [R22]
          end
          rsom_pkg::RSOM_OFF_MIRROR: begin
            if (w_strb_reg[0]) begin
              mirror_reg[7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
              mirror_reg[8] <= w_data_reg[8];
            end
          end
          default: begin
            // one action per line word [R24]
            if (wr_hit && w_strb_reg[0]) begin
              act_reg[3'(aw_addr_reg[7:2] - 6'h08)] <= w_data_reg[AW-1:0];
            end
          end
        endcase
      end
    end
  end

  // read channel; one read in flight, answer a cycle after arvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rsom_pkg::RSOM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rsom_pkg::RSOM_RESP_OKAY;
        case (s_axi_araddr)
          rsom_pkg::RSOM_OFF_CTRL: s_axi_rdata <= ctrl_reg;
          rsom_pkg::RSOM_OFF_POL: s_axi_rdata <= 32'(pol_reg);
          rsom_pkg::RSOM_OFF_MIRROR: s_axi_rdata <= {23'h0, mirror_reg};
          rsom_pkg::RSOM_OFF_STATUS: s_axi_rdata <= {28'h0, mute_reg, tone_reg,
                                                      stun_reg, settled_reg};
          rsom_pkg::RSOM_OFF_LINES: s_axi_rdata <= {16'h0, 8'(line_oe), 8'(line_out)};
          rsom_pkg::RSOM_OFF_COND: s_axi_rdata <= cond;
          default: begin
            if (s_axi_araddr >= rsom_pkg::RSOM_OFF_ACT0 && s_axi_araddr[1:0] == 2'h0
                && s_axi_araddr < 8'(rsom_pkg::RSOM_OFF_ACT0 + 4 * NUM_LINES)) begin
              s_axi_rdata <= 32'(act_reg[3'(s_axi_araddr[7:2] - 6'h08)]);
            end else begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= rsom_pkg::RSOM_RESP_SLVERR;
            end
          end
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence stun_seq;
    !trunked && stun_cmd;
  endsequence

  stun_set_a: assert property (stun_seq |=> stun_reg) // [R12]
    else $error("stun not latched");
  stun_trunk_a: assert property (trunked |-> !cond[rsom_pkg::RSOM_ACT_STUNNED] // [R13]
    ##1 $stable(stun_reg)) else $error("stun shown or changed in trunked mode");
  tone_drop_a: assert property (!carrier_detect |=> !tone_reg) // [R20]
    else $error("tone held without carrier");
  mon_hook_a: assert property (monitor_by_hook |-> !cond[rsom_pkg::RSOM_ACT_MONITOR]) // [R3]
    else $error("hook monitor shown");
  float_a: assert property (!settled_reg |=> line_oe == '0) // [R23]
    else $error("line driven before settle");
  pol_map_a: assert property (settled_reg && act_reg[2] == rsom_pkg::RSOM_ACT_HOOKSWITCH // [R22]
    && !mirror_reg[rsom_pkg::RSOM_MIR_EN] |=> line_out[2] == ($past(mic_off_hook)
    ~^ $past(pol_reg[2])))
    else $error("line level wrong");
  none_idle_a: assert property (act_reg[1] == rsom_pkg::RSOM_ACT_NONE
    && !mirror_reg[rsom_pkg::RSOM_MIR_EN] |=> line_out[1] == !$past(pol_reg[1])) // [R4]
    else $error("unassigned line active");
  ready_mode_a: assert property (mode_changing |-> !cond[rsom_pkg::RSOM_ACT_READY]) // [R11]
    else $error("ready during mode change");
  wr_resp_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("no write response");

endmodule

`default_nettype wire

/* rsom_pkg.sv */
// rsom_pkg: constants shared by the radio status output mapper
// assumes a 200 MHz aclk and a 32-bit axi4-lite register bus
package rsom_pkg;

  // status actions selectable per output line
  typedef enum logic [4:0] {
    RSOM_ACT_NONE,
    RSOM_ACT_FFSK_DATA,
    RSOM_ACT_HOOKSWITCH,
    RSOM_ACT_MONITOR,
    RSOM_ACT_DATA_TRAFFIC,
    RSOM_ACT_PUBLIC_ADDR,
    RSOM_ACT_SERVICE,
    RSOM_ACT_IDLE,
    RSOM_ACT_TRAFFIC,
    RSOM_ACT_READY,
    RSOM_ACT_STUNNED,
    RSOM_ACT_TX_STATUS,
    RSOM_ACT_PACKET_READY,
    RSOM_ACT_PTT_INHIBIT,
    RSOM_ACT_REFLECT_PTT,
    RSOM_ACT_MODEM,
    RSOM_ACT_SERIAL_TX,
    RSOM_ACT_INBAND_TONE,
    RSOM_ACT_SIG_MUTE
  } rsom_act_e;

  localparam int RSOM_ACT_W = 5;
  localparam int RSOM_NUM_LINES = 8;

  // register byte offsets
  localparam logic [7:0] RSOM_OFF_CTRL = 8'h00;
  localparam logic [7:0] RSOM_OFF_POL = 8'h04;
  localparam logic [7:0] RSOM_OFF_MIRROR = 8'h08;
  localparam logic [7:0] RSOM_OFF_STATUS = 8'h0C;
  localparam logic [7:0] RSOM_OFF_LINES = 8'h10;
  localparam logic [7:0] RSOM_OFF_COND = 8'h14;
  localparam logic [7:0] RSOM_OFF_ACT0 = 8'h20;

  // control register fields
  localparam int RSOM_CTRL_TRUNKED = 0;
  localparam int RSOM_CTRL_ENABLE = 1;
  localparam logic [31:0] RSOM_CTRL_RESET = 32'h0000_0000;

  // mirror register fields: enable bit and destination line
  localparam int RSOM_MIR_EN = 8;
  localparam int RSOM_MIR_LINE_LSB = 0;
  localparam int RSOM_MIR_LINE_W = 3;

  // reset values
  localparam logic [31:0] RSOM_POL_RESET = 32'h0000_00FF;
  localparam logic [RSOM_ACT_W-1:0] RSOM_ACT_RESET = 5'h00;

  // axi response codes
  localparam logic [1:0] RSOM_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSOM_RESP_SLVERR = 2'h2;

  // power-up settle time before the lines are driven
  localparam int RSOM_CLK_MHZ = 200;
  localparam int RSOM_SETTLE_MS = 2;
  localparam int RSOM_SETTLE_CYC = RSOM_SETTLE_MS * 1000 * RSOM_CLK_MHZ * 1000;

endpackage

/* tb.sv */
// tb: self-checking bench for the radio status output mapper
// assumes a short settle parameter and an axi4-lite slave that always answers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value %s expected %h seen %h", nm, e, g); end end

module tb;
  localparam int SETTLE = 16; // short settle time keeps the run brief
  localparam int LIMIT = 20000; // cycle ceiling, far above the expected run
  localparam logic [31:0] EN = 32'h1 << rsom_pkg::RSOM_CTRL_ENABLE;
  localparam logic [31:0] TR = 32'h1 << rsom_pkg::RSOM_CTRL_TRUNKED;
  // clock, reset and axi4-lite master side
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // radio status sources
  logic ffsk_data_valid = 1'b0, mic_off_hook = 1'b0, monitor_open = 1'b0;
  logic monitor_by_hook = 1'b0, on_data_traffic = 1'b0, on_voice_traffic = 1'b0;
  logic public_addr_mode = 1'b1, ptt_active = 1'b0, has_service = 1'b0, call_idle = 1'b0;
  logic initialised = 1'b0, mode_changing = 1'b0, stun_cmd = 1'b0, revive_cmd = 1'b0;
  logic rf_transmitting = 1'b0, data_call_possible = 1'b0, hunting_or_setup = 1'b0;
  logic ptt_inhibited = 1'b0, reflected_ptt_active = 1'b0, high_speed_data_modem = 1'b0;
  logic serial_tx_busy = 1'b0, inband_tone_valid = 1'b0, carrier_detect = 1'b0;
  logic valid_traffic = 1'b0, audio_mute_open = 1'b0, mirror_pin = 1'b0;
  logic [7:0] line_out, line_oe, pin_level;
  // bench state: expectation notes and counters
  logic [31:0] exp_q[$];
  string nm_q[$];
  int err_count = 0, total_checks = 0, cycles = 0, seed = 52895, ln;
  logic look = 1'b0;
  logic [7:0] pol;

  always #2.5 aclk = ~aclk;

  rsom_mapper #(.NUM_LINES(8), .SETTLE_CYC(SETTLE)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ffsk_data_valid, .mic_off_hook, .monitor_open,
    .monitor_by_hook, .on_data_traffic, .on_voice_traffic, .public_addr_mode,
    .ptt_active, .has_service, .call_idle, .initialised, .mode_changing, .stun_cmd,
    .revive_cmd, .rf_transmitting, .data_call_possible, .hunting_or_setup,
    .ptt_inhibited, .reflected_ptt_active, .high_speed_data_modem, .serial_tx_busy,
    .inband_tone_valid, .carrier_detect, .valid_traffic, .audio_mute_open,
    .mirror_pin, .line_out, .line_oe);

  rsom_line_reader #(.NUM_LINES(8)) i_reader (.line_out, .line_oe, .pin_level);

  // verdict and end of run, the only exit
  task automatic wrap_up;
    if (err_count == 0 && total_checks > 0 && exp_q.size() == 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // driver side: record what the next result must be
  task automatic note(input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
  endtask

  // watcher side: compare a result with the oldest note
  task automatic take(input logic [31:0] g);
    logic [31:0] e;
    string nm;
    if (exp_q.size() == 0) begin
      err_count++;
      $display("wrong value result expected none seen %h", g);
    end else begin
      e = exp_q.pop_front();
      nm = nm_q.pop_front();
      `CHK(nm, e, g)
    end
  endtask

  // watcher: every bus answer and every line look is a result
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) take({30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) begin
      take(s_axi_rdata);
      take({30'h0, s_axi_rresp});
    end
    if (look) take({24'h0, pin_level});
  end

  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw_ok, w_ok;
    note({30'h0, r}, "write response");
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 0;
    w_ok = 0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // one read with its expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                    input string nm);
    note(d, nm);
    note({30'h0, r}, "read response");
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // pin level for a set of active lines under the chosen polarity
  function automatic logic [7:0] lv(input logic [7:0] act);
    return ~(pol ^ act);
  endfunction

  // let the lines settle, then look at the connector once
  task automatic pins(input logic [7:0] e, input string nm);
    repeat (8) @(posedge aclk);
    note({24'h0, e}, nm);
    look <= 1'b1;
    @(posedge aclk);
    look <= 1'b0;
  endtask

  // raise or drop the condition behind one action; command pulses last one edge
  task automatic drive(input rsom_pkg::rsom_act_e a, input logic v);
    case (a)
      rsom_pkg::RSOM_ACT_FFSK_DATA: ffsk_data_valid <= v;
      rsom_pkg::RSOM_ACT_HOOKSWITCH: mic_off_hook <= v;
      rsom_pkg::RSOM_ACT_MONITOR: monitor_open <= v;
      rsom_pkg::RSOM_ACT_DATA_TRAFFIC: on_data_traffic <= v;
      rsom_pkg::RSOM_ACT_PUBLIC_ADDR: ptt_active <= v;
      rsom_pkg::RSOM_ACT_SERVICE: has_service <= v;
      rsom_pkg::RSOM_ACT_IDLE: call_idle <= v;
      rsom_pkg::RSOM_ACT_TRAFFIC: on_voice_traffic <= v;
      rsom_pkg::RSOM_ACT_READY: initialised <= v;
      rsom_pkg::RSOM_ACT_STUNNED: if (v) stun_cmd <= 1'b1; else revive_cmd <= 1'b1;
      rsom_pkg::RSOM_ACT_TX_STATUS: rf_transmitting <= v;
      rsom_pkg::RSOM_ACT_PACKET_READY: data_call_possible <= v;
      rsom_pkg::RSOM_ACT_PTT_INHIBIT: ptt_inhibited <= v;
      rsom_pkg::RSOM_ACT_REFLECT_PTT: reflected_ptt_active <= v;
      rsom_pkg::RSOM_ACT_MODEM: high_speed_data_modem <= v;
      rsom_pkg::RSOM_ACT_SERIAL_TX: serial_tx_busy <= v;
      rsom_pkg::RSOM_ACT_INBAND_TONE: begin
        inband_tone_valid <= v;
        carrier_detect <= v;
      end
      rsom_pkg::RSOM_ACT_SIG_MUTE: begin
        valid_traffic <= v;
        audio_mute_open <= v;
      end
      default: ;
    endcase
    @(posedge aclk);
    stun_cmd <= 1'b0;
    revive_cmd <= 1'b0;
    inband_tone_valid <= 1'b0;
    valid_traffic <= 1'b0;
  endtask

  // an action whose condition is blocked must leave its line quiet
  task automatic quiet(input rsom_pkg::rsom_act_e a, input logic trk, input string nm);
    wr(rsom_pkg::RSOM_OFF_CTRL, trk ? EN | TR : EN, rsom_pkg::RSOM_RESP_OKAY);
    wr(rsom_pkg::RSOM_OFF_ACT0 + 8'h04, 32'(a), rsom_pkg::RSOM_RESP_OKAY);
    drive(a, 1'b1);
    pins(lv(8'h00), nm);
    drive(a, 1'b0);
    wr(rsom_pkg::RSOM_OFF_ACT0 + 8'h04, 32'h0, rsom_pkg::RSOM_RESP_OKAY);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    pol = 8'($random(seed)) | 8'h04; // options board line two active high
    pins(8'hFF, "lines during settle");
    rd(rsom_pkg::RSOM_OFF_CTRL, rsom_pkg::RSOM_CTRL_RESET, 2'h0, "control reset");
    rd(rsom_pkg::RSOM_OFF_POL, rsom_pkg::RSOM_POL_RESET, 2'h0, "polarity reset");
    rd(rsom_pkg::RSOM_OFF_ACT0, 32'(rsom_pkg::RSOM_ACT_RESET), 2'h0, "action reset");
    rd(8'hFC, 32'h0, rsom_pkg::RSOM_RESP_SLVERR, "unmapped read");
    wr(8'hFC, 32'hFFFF_FFFF, rsom_pkg::RSOM_RESP_SLVERR);
    repeat (SETTLE) @(posedge aclk);
    rd(rsom_pkg::RSOM_OFF_STATUS, 32'h0000_0001, 2'h0, "status settled");
    pins(8'hFF, "lines while disabled");
    wr(rsom_pkg::RSOM_OFF_POL, {24'h0, pol}, rsom_pkg::RSOM_RESP_OKAY);
    wr(rsom_pkg::RSOM_OFF_CTRL, EN, rsom_pkg::RSOM_RESP_OKAY);
    rd(rsom_pkg::RSOM_OFF_POL, {24'h0, pol}, 2'h0, "polarity");
    pins(lv(8'h00), "unassigned lines");
    rd(rsom_pkg::RSOM_OFF_LINES, {16'h0, 8'hFF, lv(8'h00)}, 2'h0, "line readback");
    // every action on a line of its own, raised then dropped
    for (int a = 1; a <= 18; a++) begin
      ln = (a == 5) ? 2 : a % 8;
      wr(rsom_pkg::RSOM_OFF_CTRL, (a inside {4, 6, 7, 8, 12}) ? EN | TR : EN, 2'h0);
      wr(rsom_pkg::RSOM_OFF_ACT0 + 8'(4 * ln), 32'(a), rsom_pkg::RSOM_RESP_OKAY);
      drive(rsom_pkg::rsom_act_e'(5'(a)), 1'b1);
      pins(lv(8'h01 << ln), "line active");
      drive(rsom_pkg::rsom_act_e'(5'(a)), 1'b0);
      pins(lv(8'h00), "line released");
      wr(rsom_pkg::RSOM_OFF_ACT0 + 8'(4 * ln), 32'h0, rsom_pkg::RSOM_RESP_OKAY);
    end
    // blocked conditions
    monitor_by_hook <= 1'b1;
    quiet(rsom_pkg::RSOM_ACT_MONITOR, 1'b0, "monitor by hook");
    monitor_by_hook <= 1'b0;
    mode_changing <= 1'b1;
    quiet(rsom_pkg::RSOM_ACT_READY, 1'b0, "ready in mode change");
    mode_changing <= 1'b0;
    hunting_or_setup <= 1'b1;
    quiet(rsom_pkg::RSOM_ACT_PACKET_READY, 1'b1, "packet while hunting");
    hunting_or_setup <= 1'b0;
    public_addr_mode <= 1'b0;
    quiet(rsom_pkg::RSOM_ACT_PUBLIC_ADDR, 1'b0, "ptt outside pa mode");
    quiet(rsom_pkg::RSOM_ACT_STUNNED, 1'b1, "stun in trunked");
    quiet(rsom_pkg::RSOM_ACT_SERVICE, 1'b0, "service conventional");
    // mirrored pin overrides an unassigned line
    wr(rsom_pkg::RSOM_OFF_MIRROR, 32'h0000_0103, rsom_pkg::RSOM_RESP_OKAY);
    mirror_pin <= 1'b1;
    pins(lv(8'h08), "mirror high");
    mirror_pin <= 1'b0;
    pins(lv(8'h00), "mirror low");
    repeat (4) @(posedge aclk);
    wrap_up();
  end
endmodule

`default_nettype wire
